//--- hw/cal_frame_pkg.sv
// constants for the offset calibration frame control
package cal_frame_pkg;
  localparam int          RESULT_W          = 12;
  localparam int          COUNT_W           = 6;
  localparam logic [5:0]  LEAD_ZEROS        = 6'h02;
  localparam logic [5:0]  DATA_LAST_EDGE    = 6'h0e;
  localparam logic [5:0]  PWRUP_CAL_EDGES   = 6'h10;
  localparam logic [5:0]  NORM_CAL_START    = 6'h11;
  localparam logic [5:0]  NORM_CAL_END      = 6'h20;
  localparam logic [5:0]  COUNT_MAX         = 6'h3f;
  localparam logic [11:0] OFFSET_RESET      = 12'h000;
  localparam logic [11:0] CODE_MID          = 12'h800;
  localparam logic [11:0] CODE_FULL         = 12'hfff;
  localparam int          SYS_CLK_HZ        = 50000000;
  localparam int          ACQ_TIME_NS       = 200;
  localparam int          ACQ_CYCLES        = (ACQ_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int          FIFO_DEPTH        = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_CAL, ST_LOW} frame_state_t;
endpackage

//--- hw/result_fifo.sv
// small valid/ready fifo holding conversion results
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // honest full and empty from the occupancy count
  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_q[rd_ptr_q];

  // storage, written only on an accepted push
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- hw/adc_offset_calibration_frame.sv
// frame control, offset calibration and serial output of the converter
`timescale 1ns/1ps
module adc_offset_calibration_frame
  import cal_frame_pkg::*;
#(
  parameter int W = RESULT_W
) (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // serial pins
  input  wire logic         cs_n_in,
  input  wire logic         sclk_in,
  output logic              sdo_out,
  output logic              sdo_oe_out,
  // raw converter side
  input  wire logic         raw_valid_in,
  output logic              raw_ready_out,
  input  wire logic [W-1:0] raw_code_in,
  input  wire logic [W-1:0] cal_offset_in,
  // status
  output logic              calibrated_out,
  output logic              cal_busy_out,
  output logic              acq_ready_out
);
  logic             cs_meta_q;
  logic             cs_sync_q;
  logic             cs_prev_q;
  logic             sclk_meta_q;
  logic             sclk_sync_q;
  logic             sclk_prev_q;
  logic             cs_fall;
  logic             cs_rise;
  logic             sclk_fall;
  logic [COUNT_W-1:0] edge_cnt_q;
  frame_state_t     state_q;
  logic             first_frame_q;
  logic             powerup_frame_q;
  logic [W-1:0]     offset_correction_store_q;
  logic [W-1:0]     cal_hold_q;
  logic [W+1:0]     shift_q;
  logic             sdo_q;
  logic             oe_q;
  logic             calibrated_q;
  logic [7:0]       acq_cnt_q;
  logic             fifo_valid;
  logic             fifo_ready;
  logic [W-1:0]     fifo_data;
  logic [W-1:0]     corrected;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cs_meta_q   <= 1'b1;
      cs_sync_q   <= 1'b1;
      cs_prev_q   <= 1'b1;
      sclk_meta_q <= 1'b0;
      sclk_sync_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_meta_q   <= cs_n_in;
      cs_sync_q   <= cs_meta_q;
      cs_prev_q   <= cs_sync_q;
      sclk_meta_q <= sclk_in;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
    end
  end

  assign cs_fall   = cs_prev_q && !cs_sync_q;
  assign cs_rise   = !cs_prev_q && cs_sync_q;
  // clock edges only count inside a frame
  assign sclk_fall = sclk_prev_q && !sclk_sync_q && !cs_sync_q;

  // raw results are buffered so a late converter never tears a frame
  result_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (raw_valid_in),
    .wr_ready_out (raw_ready_out),
    .wr_data_in   (raw_code_in),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_ready),
    .rd_data_out  (fifo_data)
  );

  // one result is drained per normal frame, at its chip select fall
  assign fifo_ready = cs_fall && !first_frame_q;

  // offset subtract
  // saturate so a correction near the rails cannot wrap the code
  always_comb begin
    corrected = fifo_data - offset_correction_store_q;
    if (fifo_data < offset_correction_store_q) begin
      corrected = '0;
    end
  end

  // frame edge count
  // saturates so very long frames cannot alias back into the windows
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || cs_rise || cs_fall) begin
      edge_cnt_q <= '0;
    end else if (sclk_fall && edge_cnt_q != COUNT_MAX) begin
      edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  // frame state: data phase, calibration phase, trailing low phase
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q         <= ST_IDLE;
      first_frame_q   <= 1'b1;
      powerup_frame_q <= 1'b0;
    end else if (cs_rise) begin
      state_q         <= ST_IDLE;
      powerup_frame_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q         <= first_frame_q ? ST_CAL : ST_DATA;
            powerup_frame_q <= first_frame_q;
            first_frame_q   <= 1'b0;
          end
        end
        ST_DATA: begin
          if (sclk_fall && edge_cnt_q == NORM_CAL_START - 6'h01) begin
            state_q <= ST_CAL;
          end
        end
        ST_CAL: begin
          if (sclk_fall && powerup_frame_q && edge_cnt_q == PWRUP_CAL_EDGES - 6'h01) begin
            state_q <= ST_LOW;
          end else if (sclk_fall && !powerup_frame_q &&
                       edge_cnt_q == NORM_CAL_END - 6'h01) begin
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          state_q <= ST_LOW;
        end
      endcase
    end
  end

  // captured at calibration start; held until the closing edge
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cal_hold_q <= OFFSET_RESET;
    end else if (state_q != ST_CAL) begin
      cal_hold_q <= cal_offset_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      offset_correction_store_q <= OFFSET_RESET;
      calibrated_q              <= 1'b0;
    end else if (state_q == ST_CAL && sclk_fall && !cs_rise) begin
      if ((powerup_frame_q && edge_cnt_q == PWRUP_CAL_EDGES - 6'h01) ||
          (!powerup_frame_q && edge_cnt_q == NORM_CAL_END - 6'h01)) begin
        offset_correction_store_q <= cal_hold_q;
        calibrated_q              <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shift_q <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (cs_rise) begin
      oe_q  <= 1'b0;
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      oe_q    <= 1'b1;
      sdo_q   <= 1'b0;
      shift_q <= (first_frame_q || !fifo_valid) ? '0 : {2'b00, corrected};
    end else if (sclk_fall) begin
      shift_q <= {shift_q[W:0], 1'b0};
      sdo_q   <= (edge_cnt_q < DATA_LAST_EDGE - 6'h01) ? shift_q[W] : 1'b0;
    end
  end

  // acquisition interval
  // only reported, the host owns the wait
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      acq_cnt_q <= '0;
    end else if (state_q == ST_CAL || cs_fall) begin
      acq_cnt_q <= 8'(ACQ_CYCLES);
    end else if (acq_cnt_q != '0) begin
      acq_cnt_q <= acq_cnt_q - 1'b1;
    end
  end

  assign sdo_out        = sdo_q;
  assign sdo_oe_out     = oe_q;
  assign calibrated_out = calibrated_q;
  assign cal_busy_out   = (state_q == ST_CAL);
  assign acq_ready_out  = (acq_cnt_q == '0);
endmodule

//--- verification/adc_offset_calibration_frame_props.sv
// port assertions for the calibration frame control
`timescale 1ns/1ps
module cal_frame_props
  import cal_frame_pkg::*;
#(
  parameter int W = RESULT_W
) (
  // ports of the watched block
  input wire logic         sys_clk_in,
  input wire logic         rst_in,
  input wire logic         cs_n_in,
  input wire logic         sclk_in,
  input wire logic         sdo_out,
  input wire logic         sdo_oe_out,
  input wire logic         raw_valid_in,
  input wire logic         raw_ready_out,
  input wire logic [W-1:0] raw_code_in,
  input wire logic [W-1:0] cal_offset_in,
  input wire logic         calibrated_out,
  input wire logic         cal_busy_out,
  input wire logic         acq_ready_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // pins pass a 2-flop sync, so windows leave a few cycles of slack
  oe_idle_a: assert property (cs_n_in [*6] |-> !sdo_oe_out)
    else $error("output driven while idle");
  oe_drive_a: assert property ($fell(cs_n_in) ##1 !cs_n_in [*5] |-> sdo_oe_out)
    else $error("output not driven in frame");
  first_zero_a: assert property ($rose(sdo_oe_out) |-> !sdo_out)
    else $error("first bit not zero");
  busy_quiet_a: assert property (cal_busy_out && sdo_oe_out |-> !sdo_out)
    else $error("data high during calibration");
  cal_sticky_a: assert property (calibrated_out |=> calibrated_out)
    else $error("calibrated flag dropped");
  cal_done_a: assert property ($rose(calibrated_out) |-> $past(cal_busy_out))
    else $error("store written outside calibration");
  busy_frame_a: assert property ($rose(cal_busy_out) |-> !cs_n_in)
    else $error("calibration outside a frame");
  // a calibration keeps reloading the wait, so only frame starts outside it count here
  acq_wait_a: assert property ($fell(acq_ready_out) && !cal_busy_out |->
      !acq_ready_out [*8] ##[1:4] acq_ready_out)
    else $error("acquisition wait wrong");
  // the wait runs out a fixed time after a calibration ends, finished or cut
  acq_after_cal_a: assert property ($fell(cal_busy_out) |->
      !acq_ready_out [*8] ##[1:4] acq_ready_out)
    else $error("acquisition wait after calibration wrong");
endmodule
bind adc_offset_calibration_frame cal_frame_props #(.W(W)) u_cal_frame_props (
  .sys_clk_in, .rst_in, .cs_n_in, .sclk_in, .sdo_out, .sdo_oe_out, .raw_valid_in,
  .raw_ready_out, .raw_code_in, .cal_offset_in, .calibrated_out, .cal_busy_out,
  .acq_ready_out
);

//--- verification/host_model.sv
// host model driving chip select and serial clock, gathering data
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic sys_clk_in,
  // serial pins
  output logic      cs_n_out,
  output logic      sclk_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  // serial clock rests low between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
  end
  // one frame of n clocks; an undriven pin reads as unknown in the first 14 bits and sets tl after them
  task automatic frame(input int n, output logic [13:0] w, output logic tl);
    w = 14'h0000;
    tl = 1'b0;
    @(posedge sys_clk_in) cs_n_out <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    for (int k = 0; k < n; k++) begin
      sclk_out <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      if (k < 14) w = {w[12:0], sdo_oe_in ? sdo_in : 1'bx};
      else tl = tl | sdo_in | !sdo_oe_in;
      @(posedge sys_clk_in) sclk_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
    repeat (4) @(posedge sys_clk_in);
    cs_n_out <= 1'b1;
    // high time covers the acquisition wait
    repeat (14) @(posedge sys_clk_in);
  endtask
endmodule

//--- verification/adc_offset_calibration_frame_tb.sv
// self-checking bench for the calibration frame control
`timescale 1ns/1ps
module adc_offset_calibration_frame_tb;
  import cal_frame_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        raw_valid_in = 1'b0;
  logic [11:0] raw_code_in = 12'h000;
  logic [11:0] cal_offset_in = 12'h000;
  logic [11:0] store;
  logic [11:0] q[$];
  logic        cs_n_in, sclk_in, sdo_out, sdo_oe_out, raw_ready_out, tl, cal_done;
  logic        calibrated_out, cal_busy_out, acq_ready_out;
  logic [13:0] w;
  int          n_fail = 0;
  int          checks = 0;
  // 50 MHz clock
  always #10 sys_clk_in = ~sys_clk_in;
  adc_offset_calibration_frame u_adc_offset_calibration_frame (
    .sys_clk_in, .rst_in, .cs_n_in, .sclk_in, .sdo_out, .sdo_oe_out, .raw_valid_in,
    .raw_ready_out, .raw_code_in, .cal_offset_in, .calibrated_out, .cal_busy_out,
    .acq_ready_out
  );
  host_model u_host_model (
    .sys_clk_in, .cs_n_out(cs_n_in), .sclk_out(sclk_in), .sdo_in(sdo_out),
    .sdo_oe_in(sdo_oe_out)
  );
  // corrected result floors at zero rather than wrapping
  function automatic logic [13:0] corrected(input logic [11:0] c, input logic [11:0] s);
    return (c > s) ? {2'b00, c - s} : 14'h0000;
  endfunction
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(posedge sys_clk_in) rst_in <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    cal_offset_in <= 12'($urandom_range(200, 1));
    q.delete();
    store = 12'h000;
    cal_done = 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  // offer ten words; the eight-deep buffer must refuse the last two
  task automatic fill;
    logic [11:0] c;
    for (int i = 0; i < 10; i++) begin
      c = (i == 4) ? 12'hfff : (i == 5) ? 12'h000 : 12'($urandom);
      @(posedge sys_clk_in);
      raw_valid_in <= 1'b1;
      raw_code_in <= c;
      @(negedge sys_clk_in);
      if (raw_ready_out === 1'b1) q.push_back(c);
    end
    @(posedge sys_clk_in);
    raw_valid_in <= 1'b0;
    check(14'(q.size()), 14'h0008); // exactly eight offered words are accepted
  endtask
  task automatic run(input int n, input bit first);
    logic [13:0] e;
    e = (first || q.size() == 0) ? 14'h0000 : corrected(q.pop_front(), store);
    u_host_model.frame(n, w, tl);
    check(w, e); // corrected word with two leading zeros
    check({13'h0000, tl}, 14'h0000); // low after the data bits
    if (n >= (first ? 16 : 32)) begin
      store = cal_offset_in;
      cal_done = 1'b1;
    end
    check({13'h0000, calibrated_out}, {13'h0000, cal_done}); // store written
  endtask
  // main sequence with a second reset in mid-run
  initial begin
    void'($urandom(32'h0578));
    do_reset();
    run(10, 1'b1); // short power-up frame
    fill();
    run(14, 1'b0); // plain frame
    run(31, 1'b0); // one clock short of calibration
    run(32, 1'b0); // calibration frame
    @(posedge sys_clk_in) cal_offset_in <= 12'($urandom);
    for (int i = 0; i < 6; i++) run(14 + $urandom_range(16, 0), 1'b0);
    do_reset();
    fill();
    run(16, 1'b1); // full power-up calibration
    run(20, 1'b0); // result after power-up calibration
    final_report();
  end
  // twelve frames of at most 300 cycles, with wide margin
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule
